// ==== hw/ssp_pkg.sv ====
// Purpose : Shared constants for the sequencer special ports block
// Assumes : Register index n sits at APB byte address 4*n
// Notes   : Indices are 8 bits; narrower values sit in the low bits, except the decode operand in bits 6 to 4
package ssp_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] SSP_IDX_SRC_PTR   = 8'h65;
    localparam logic [7:0] SSP_IDX_DST_PTR   = 8'h66;
    localparam logic [7:0] SSP_IDX_NULL_SINK = 8'h6A;
    localparam logic [7:0] SSP_IDX_FLAGS     = 8'h6B;
    localparam logic [7:0] SSP_IDX_IND_SRC   = 8'h6C;
    localparam logic [7:0] SSP_IDX_IND_DST   = 8'h6D;
    localparam logic [7:0] SSP_IDX_DECODE    = 8'h6E;
    localparam logic [7:0] SSP_IDX_STACK     = 8'h6F;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int SSP_FLAG_ZERO_BIT  = 1;
    localparam int SSP_FLAG_CARRY_BIT = 0;
    localparam int SSP_OPND_LSB       = 4;
    localparam int SSP_OPND_MSB       = 6;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int SSP_APB_AW     = 10;
    localparam int SSP_RET_AW     = 9;
    localparam int SSP_STACK_D    = 4;
    localparam logic [7:0] SSP_PTR_RST   = 8'h00;
    localparam logic [2:0] SSP_OPND_RST  = 3'h0;
    localparam logic [8:0] SSP_RET_RST   = 9'h000;
    localparam logic [31:0] SSP_RDATA_RST = 32'h0000_0000;
endpackage : ssp_pkg

// ==== hw/ssp_ret_stack.sv ====
// Purpose : Four-entry return stack with byte-wise read-out
// Assumes : Push and pop come from the instruction engine, never both at once
// Notes   : Read-out rotates the stack; eight reads restore the original top
`timescale 1ns/1ps
`default_nettype none
module ssp_ret_stack (
    input  wire logic                             i_core_clk,
    input  wire logic                             i_rstn,
    input  wire logic                             i_push,
    input  wire logic [ssp_pkg::SSP_RET_AW-1:0]   i_push_addr,
    input  wire logic                             i_pop,
    input  wire logic                             i_read_strobe,
    output logic      [ssp_pkg::SSP_RET_AW-1:0]   o_top,
    output logic      [7:0]                       o_read_byte
);
    typedef struct packed {
        logic [ssp_pkg::SSP_STACK_D-1:0][ssp_pkg::SSP_RET_AW-1:0] entry;
        logic [1:0]                                              top;
        logic                                                    hi;
    } ssp_stk_t;

    ssp_stk_t st_ff;
    ssp_stk_t nxt_st;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (i_push) begin
            nxt_st.top = st_ff.top - 2'd1;
            nxt_st.entry[st_ff.top - 2'd1] = i_push_addr;
            nxt_st.hi = 1'b0;
        end else if (i_pop) begin
            nxt_st.top = st_ff.top + 2'd1;
            nxt_st.hi = 1'b0;
        end else if (i_read_strobe) begin
            nxt_st.hi = ~st_ff.hi;
            // Only the high-byte read moves to the next older entry
            if (st_ff.hi) begin
                nxt_st.top = st_ff.top + 2'd1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Location top is the entry at the top, location top+k is k entries older
    assign o_top = st_ff.entry[st_ff.top];
    assign o_read_byte = st_ff.hi
        ? {{(16 - ssp_pkg::SSP_RET_AW){1'b0}}, o_top[ssp_pkg::SSP_RET_AW-1:8]}
        : o_top[7:0];
endmodule : ssp_ret_stack
`default_nettype wire

// ==== hw/ssp_special_ports.sv ====
// Purpose : Special ports of the sequencer datapath with an APB host view
// Assumes : Host accesses happen while the instruction engine is paused
// Notes   : Sequencer reads answer one cycle later from flip-flops
//           Host accesses wait while the sequencer drives a port
//           Index registers are seen only by the sequencer
//           Stack read-out walks the same stack that the engine pops
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ssp_special_ports (
    // Clock and reset
    input  wire logic                             i_core_clk,
    input  wire logic                             i_rstn,

    // APB slave
    input  wire logic                             i_psel,
    input  wire logic                             i_penable,
    input  wire logic                             i_pwrite,
    input  wire logic [ssp_pkg::SSP_APB_AW-1:0]   i_paddr,
    input  wire logic [31:0]                      i_pwdata,
    input  wire logic [3:0]                       i_pstrb,
    output logic                                  o_pready,
    output logic      [31:0]                      o_prdata,
    output logic                                  o_pslverr,

    // Sequencer port access
    input  wire logic                             i_seq_rd,
    input  wire logic [7:0]                       i_seq_rd_addr,
    output logic                                  o_seq_rd_valid,
    output logic      [7:0]                       o_seq_rd_data,
    input  wire logic                             i_seq_wr,
    input  wire logic [7:0]                       i_seq_wr_addr,
    input  wire logic [7:0]                       i_seq_wr_data,

    // Scratch memory behind the indirect ports
    output logic      [7:0]                       o_mem_rd_addr,
    input  wire logic [7:0]                       i_mem_rd_data,
    output logic                                  o_mem_wr,
    output logic      [7:0]                       o_mem_wr_addr,
    output logic      [7:0]                       o_mem_wr_data,

    // ALU result feedback
    input  wire logic                             i_alu_done,
    input  wire logic                             i_alu_arith,
    input  wire logic [7:0]                       i_alu_result,
    input  wire logic                             i_alu_carry,

    // Return stack control
    input  wire logic                             i_stack_push,
    input  wire logic [ssp_pkg::SSP_RET_AW-1:0]   i_stack_push_addr,
    input  wire logic                             i_stack_pop,
    output logic      [ssp_pkg::SSP_RET_AW-1:0]   o_stack_top,
    // Index registers as the engine sees them
    output logic      [7:0]                       o_src_ptr,
    output logic      [7:0]                       o_dst_ptr
);
    typedef struct packed {
        // Host bus answer
        logic        apb_ack;
        logic [31:0] prdata;
        logic        pslverr;

        // Sequencer read answer
        logic        seq_rd_valid;
        logic [7:0]  seq_rd_data;

        // Index registers and decode operand
        logic [7:0]  src_ptr;
        logic [7:0]  dst_ptr;
        logic [2:0]  operand;

        // Flags
        logic        zero;
        logic        carry;

        // Indirect store towards scratch memory
        logic        mem_wr;
        logic [7:0]  mem_wr_addr;
        logic [7:0]  mem_wr_data;
    } ssp_state_t;

    ssp_state_t st_ff;
    ssp_state_t nxt_st;

    // Read values offered to both masters
    logic [7:0] stack_byte;
    logic [7:0] one_hot;
    logic [7:0] flag_byte;

    // Host decode and handshake
    logic [7:0] apb_idx;
    logic       apb_aligned;
    logic       seq_busy;
    logic       apb_rd_ok;
    logic       apb_wr_ok;
    logic       apb_done;
    logic [7:0] apb_byte;

    // Stack read-out strobes
    logic       host_stack_rd;
    logic       seq_stack_rd;
    logic       stack_rd;

    // ------------------------------------------------------------
    // Shared read values
    // ------------------------------------------------------------
    // One comparator per bit of the decoded byte
    for (genvar b = 0; b < 8; b++) begin : g_hot
        assign one_hot[b] = (st_ff.operand == 3'(b));
    end

    // Bits 7 to 2 of the flag view always read as zero
    always_comb begin
        flag_byte = 8'h00;
        flag_byte[ssp_pkg::SSP_FLAG_ZERO_BIT]  = st_ff.zero;
        flag_byte[ssp_pkg::SSP_FLAG_CARRY_BIT] = st_ff.carry;
    end

    // ------------------------------------------------------------
    // Host decode
    // ------------------------------------------------------------
    assign apb_idx     = i_paddr[ssp_pkg::SSP_APB_AW-1:2];
    assign apb_aligned = (i_paddr[1:0] == 2'b00);
    assign seq_busy    = i_seq_rd | i_seq_wr;

    // The indirect ports and index registers are left out of the host map
    always_comb begin
        apb_rd_ok = 1'b0;
        apb_wr_ok = 1'b0;
        apb_byte  = 8'h00;
        if (apb_aligned) begin
            // Misaligned addresses stay refused
            case (apb_idx)
                ssp_pkg::SSP_IDX_NULL_SINK: begin
                    apb_rd_ok = 1'b1;
                    apb_wr_ok = 1'b1;
                    apb_byte  = 8'h00;
                end

                ssp_pkg::SSP_IDX_FLAGS: begin
                    apb_rd_ok = 1'b1;
                    apb_wr_ok = 1'b1;
                    apb_byte  = flag_byte;
                end

                ssp_pkg::SSP_IDX_DECODE: begin
                    apb_rd_ok = 1'b1;
                    apb_wr_ok = 1'b1;
                    apb_byte  = one_hot;
                end

                ssp_pkg::SSP_IDX_STACK: begin
                    apb_rd_ok = 1'b1;
                    apb_wr_ok = 1'b1;
                    apb_byte  = stack_byte;
                end

                default: begin
                    // Refused: no effect, zero data, error answer
                    apb_rd_ok = 1'b0;
                    apb_wr_ok = 1'b0;
                    apb_byte  = 8'h00;
                end
            endcase
        end
    end

    // Access phase: one wait cycle latches data, the next completes it.
    // The wait state costs a cycle but keeps prdata and pready on flops,
    // so the host never samples a value that is still being decoded.
    assign apb_done = i_psel & i_penable & st_ff.apb_ack;

    // Both the host and the sequencer may walk the stack read-out;
    // reads from both in one cycle count as a single step
    assign host_stack_rd = apb_done & ~i_pwrite & ~st_ff.pslverr
                         & (apb_idx == ssp_pkg::SSP_IDX_STACK);
    assign seq_stack_rd  = i_seq_rd & (i_seq_rd_addr == ssp_pkg::SSP_IDX_STACK);
    assign stack_rd      = host_stack_rd | seq_stack_rd;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.seq_rd_valid = 1'b0;
        nxt_st.mem_wr = 1'b0;

        // Host side: the completion edge retires the answer
        if (apb_done) begin
            nxt_st.apb_ack = 1'b0;
            // Only byte lane 0 carries the port byte
            if (i_pwrite & ~st_ff.pslverr & i_pstrb[0]
                & (apb_idx == ssp_pkg::SSP_IDX_DECODE)) begin
                nxt_st.operand =
                    i_pwdata[ssp_pkg::SSP_OPND_MSB:ssp_pkg::SSP_OPND_LSB];
            end
        end else if (i_psel & i_penable & ~seq_busy) begin
            // Sequencer traffic holds off the latch so the data stays coherent
            nxt_st.apb_ack = 1'b1;
            if (i_pwrite) begin
                nxt_st.pslverr = ~apb_wr_ok;
                nxt_st.prdata  = ssp_pkg::SSP_RDATA_RST;
            end else begin
                nxt_st.pslverr = ~apb_rd_ok;
                nxt_st.prdata  = apb_rd_ok ? {24'h00_0000, apb_byte}
                                           : ssp_pkg::SSP_RDATA_RST;
            end
        end

        // Sequencer reads
        if (i_seq_rd) begin
            nxt_st.seq_rd_valid = 1'b1;
            case (i_seq_rd_addr)
                ssp_pkg::SSP_IDX_SRC_PTR: begin
                    nxt_st.seq_rd_data = st_ff.src_ptr;
                end

                ssp_pkg::SSP_IDX_DST_PTR: begin
                    nxt_st.seq_rd_data = st_ff.dst_ptr;
                end

                ssp_pkg::SSP_IDX_NULL_SINK: begin
                    nxt_st.seq_rd_data = 8'h00;
                end

                ssp_pkg::SSP_IDX_FLAGS: begin
                    nxt_st.seq_rd_data = flag_byte;
                end

                ssp_pkg::SSP_IDX_IND_SRC: begin
                    nxt_st.seq_rd_data = i_mem_rd_data;
                    nxt_st.src_ptr = st_ff.src_ptr + 8'h01;
                end

                ssp_pkg::SSP_IDX_DECODE: begin
                    nxt_st.seq_rd_data = one_hot;
                end

                ssp_pkg::SSP_IDX_STACK: begin
                    nxt_st.seq_rd_data = stack_byte;
                end

                default: begin
                    // Unmapped and write-only ports read as zero
                    nxt_st.seq_rd_data = 8'h00;
                end
            endcase
        end

        // Sequencer writes; a pointer load wins over its own increment
        if (i_seq_wr) begin
            case (i_seq_wr_addr)
                ssp_pkg::SSP_IDX_SRC_PTR: begin
                    nxt_st.src_ptr = i_seq_wr_data;
                end
                ssp_pkg::SSP_IDX_DST_PTR: begin
                    nxt_st.dst_ptr = i_seq_wr_data;
                end
                ssp_pkg::SSP_IDX_IND_DST: begin
                    nxt_st.mem_wr      = 1'b1;
                    nxt_st.mem_wr_addr = st_ff.dst_ptr;
                    nxt_st.mem_wr_data = i_seq_wr_data;
                    nxt_st.dst_ptr     = st_ff.dst_ptr + 8'h01;
                end
                ssp_pkg::SSP_IDX_DECODE: begin
                    nxt_st.operand =
                        i_seq_wr_data[ssp_pkg::SSP_OPND_MSB:ssp_pkg::SSP_OPND_LSB];
                end
                default: begin
                    // Null sink and read-only ports: the data is dropped
                    nxt_st.mem_wr = 1'b0;
                end
            endcase
        end

        // Flags follow each ALU result; logical operations keep the carry,
        // since a logical step has no carry out of its own
        if (i_alu_done) begin
            nxt_st.zero = (i_alu_result == 8'h00);
            if (i_alu_arith) begin
                nxt_st.carry = i_alu_carry;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------
    // Push and pop come straight from the engine
    ssp_ret_stack u_stack (
        .i_core_clk    (i_core_clk),
        .i_rstn        (i_rstn),
        .i_push        (i_stack_push),
        .i_push_addr   (i_stack_push_addr),
        .i_pop         (i_stack_pop),
        .i_read_strobe (stack_rd),
        .o_top         (o_stack_top),
        .o_read_byte   (stack_byte)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Host bus
    assign o_pready       = st_ff.apb_ack;
    assign o_prdata       = st_ff.prdata;
    assign o_pslverr      = st_ff.pslverr & st_ff.apb_ack;

    // Sequencer read answer
    assign o_seq_rd_valid = st_ff.seq_rd_valid;
    assign o_seq_rd_data  = st_ff.seq_rd_data;

    // Scratch memory
    assign o_mem_rd_addr  = st_ff.src_ptr;
    assign o_mem_wr       = st_ff.mem_wr;
    assign o_mem_wr_addr  = st_ff.mem_wr_addr;
    assign o_mem_wr_data  = st_ff.mem_wr_data;

    // Index registers
    assign o_src_ptr      = st_ff.src_ptr;
    assign o_dst_ptr      = st_ff.dst_ptr;
endmodule : ssp_special_ports
`default_nettype wire

// ==== verif/ssp_sp_assertions.sv ====
// Purpose : Concurrent checks on the sequencer and host ports
// Assumes : Bound to ssp_special_ports
// Notes   : Flag contents and stack order are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module ssp_sp_assertions (
    input wire logic                           i_core_clk,
    input wire logic                           i_rstn,
    input wire logic                           i_psel,
    input wire logic                           i_penable,
    input wire logic [ssp_pkg::SSP_APB_AW-1:0] i_paddr,
    input wire logic                           o_pready,
    input wire logic                           o_pslverr,
    input wire logic                           i_seq_rd,
    input wire logic [7:0]                     i_seq_rd_addr,
    input wire logic                           o_seq_rd_valid,
    input wire logic [7:0]                     o_seq_rd_data,
    input wire logic                           i_seq_wr,
    input wire logic [7:0]                     i_seq_wr_addr,
    input wire logic [7:0]                     i_seq_wr_data,
    input wire logic [7:0]                     i_mem_rd_data,
    input wire logic                           o_mem_wr,
    input wire logic [7:0]                     o_mem_wr_addr,
    input wire logic [7:0]                     o_mem_wr_data,
    input wire logic [7:0]                     o_src_ptr,
    input wire logic [7:0]                     o_dst_ptr
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_rd(logic [7:0] a);
        i_seq_rd && i_seq_rd_addr == a;
    endsequence
    sequence s_wr(logic [7:0] a);
        i_seq_wr && i_seq_wr_addr == a;
    endsequence
    chk_null_drop: assert property (s_wr(8'h6A) ##0 !i_seq_rd |=>
        !o_mem_wr && $stable(o_src_ptr) && $stable(o_dst_ptr)) else $error("sink write had effect");
    chk_zero_read: assert property (s_rd(8'h6A) |=>
        o_seq_rd_valid && o_seq_rd_data == 8'h00) else $error("zero source not zero");
    chk_flag_upper: assert property (s_rd(8'h6B) |=>
        o_seq_rd_data[7:2] == 6'h00) else $error("flag view upper bits set");
    chk_src_fetch: assert property (s_rd(8'h6C) |=>
        o_seq_rd_valid && o_seq_rd_data == $past(i_mem_rd_data)) else $error("bad indirect fetch");
    chk_src_step: assert property (s_rd(8'h6C) ##0 !i_seq_wr |=>
        o_src_ptr == $past(o_src_ptr) + 8'h01) else $error("source pointer step wrong");
    chk_dst_store: assert property (s_wr(8'h6D) |=> o_mem_wr &&
        o_mem_wr_addr == $past(o_dst_ptr) && o_mem_wr_data == $past(i_seq_wr_data))
        else $error("bad indirect store");
    chk_dst_step: assert property (s_wr(8'h6D) |=>
        o_dst_ptr == $past(o_dst_ptr) + 8'h01) else $error("dest pointer step wrong");
    chk_host_refuse: assert property (i_psel && i_penable && o_pready &&
        i_paddr[9:2] inside {8'h6C, 8'h6D} |-> o_pslverr) else $error("indirect port host visible");
    chk_decode_hot: assert property (s_rd(8'h6E) |=>
        $onehot(o_seq_rd_data)) else $error("decode not one-hot");
endmodule : ssp_sp_assertions
bind ssp_special_ports ssp_sp_assertions u_chk (
    .i_core_clk, .i_rstn, .i_psel, .i_penable, .i_paddr, .o_pready, .o_pslverr,
    .i_seq_rd, .i_seq_rd_addr, .o_seq_rd_valid, .o_seq_rd_data, .i_seq_wr,
    .i_seq_wr_addr, .i_seq_wr_data, .i_mem_rd_data, .o_mem_wr, .o_mem_wr_addr,
    .o_mem_wr_data, .o_src_ptr, .o_dst_ptr
);
`default_nettype wire

// ==== verif/ssp_sp_scratch_mem.sv ====
// Purpose : Scratch memory model behind the indirect ports
// Assumes : Read data is combinational from the current read address
// Notes   : Preloaded with k ^ 8'hA5 so each location is distinct
`timescale 1ns/1ps
`default_nettype none
module ssp_sp_scratch_mem (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rd_addr,
    output logic      [7:0] o_rd_data,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wr_addr,
    input  wire logic [7:0] i_wr_data
);
    logic [7:0] mem [256];
    initial begin
        for (int k = 0; k < 256; k++) begin
            mem[k] = 8'(k) ^ 8'hA5;
        end
    end
    assign o_rd_data = mem[i_rd_addr];
    always @(posedge i_core_clk) begin
        if (i_wr) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end
endmodule : ssp_sp_scratch_mem
`default_nettype wire

// ==== verif/ssp_special_ports_tb_top.sv ====
// Purpose : Self-checking bench for the sequencer special ports
// Assumes : Host accesses only while no sequencer traffic is driven
// Notes   : Expected memory bytes follow the model preload k ^ 8'hA5
`timescale 1ns/1ps
`default_nettype none
module ssp_special_ports_tb_top;
    logic        i_core_clk = 1'b0, i_rstn = 1'b0;
    logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [ssp_pkg::SSP_APB_AW-1:0] i_paddr = 10'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata;
    logic [3:0]  i_pstrb = 4'hF;
    logic        o_pready, o_pslverr, o_seq_rd_valid, o_mem_wr;
    logic        i_seq_rd = 1'b0, i_seq_wr = 1'b0, i_alu_done = 1'b0;
    logic        i_alu_arith = 1'b0, i_alu_carry = 1'b0;
    logic        i_stack_push = 1'b0, i_stack_pop = 1'b0;
    logic [7:0]  i_seq_rd_addr = 8'h00, i_seq_wr_addr = 8'h00;
    logic [7:0]  i_seq_wr_data = 8'h00, i_alu_result = 8'h00;
    logic [7:0]  o_seq_rd_data, o_mem_rd_addr, i_mem_rd_data;
    logic [7:0]  o_mem_wr_addr, o_mem_wr_data, o_src_ptr, o_dst_ptr;
    logic [8:0]  i_stack_push_addr = 9'h000, o_stack_top;
    int          bad_count = 0, cmp_count = 0;

    always #12.5 i_core_clk = ~i_core_clk;
    ssp_special_ports dut (
        .i_core_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .i_pstrb, .o_pready, .o_prdata, .o_pslverr, .i_seq_rd, .i_seq_rd_addr,
        .o_seq_rd_valid, .o_seq_rd_data, .i_seq_wr, .i_seq_wr_addr, .i_seq_wr_data,
        .o_mem_rd_addr, .i_mem_rd_data, .o_mem_wr, .o_mem_wr_addr, .o_mem_wr_data,
        .i_alu_done, .i_alu_arith, .i_alu_result, .i_alu_carry, .i_stack_push,
        .i_stack_push_addr, .i_stack_pop, .o_stack_top, .o_src_ptr, .o_dst_ptr
    );
    ssp_sp_scratch_mem u_mem (
        .i_core_clk, .i_rd_addr(o_mem_rd_addr), .o_rd_data(i_mem_rd_data),
        .i_wr(o_mem_wr), .i_wr_addr(o_mem_wr_addr), .i_wr_data(o_mem_wr_data)
    );
    // ----
    // Bus and port tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= {idx, 2'b00};
        i_pwdata <= wd;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (o_pready !== 1'b1) begin
            bad_count++;
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    task automatic hr(input logic [7:0] idx, input logic [31:0] exp, input logic e = 1'b0);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 32'h0, rd, err);
        chk({31'h0, err}, {31'h0, e});
        chk(rd, exp);
    endtask : hr
    task automatic hw(input logic [7:0] idx, input logic [31:0] wd, input logic e = 1'b0);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, wd, rd, err);
        chk({31'h0, err}, {31'h0, e});
    endtask : hw
    task automatic sq(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_seq_rd <= !wr;
        i_seq_wr <= wr;
        i_seq_rd_addr <= a;
        i_seq_wr_addr <= a;
        i_seq_wr_data <= d;
        @(posedge i_core_clk);
        i_seq_rd <= 1'b0;
        i_seq_wr <= 1'b0;
        @(negedge i_core_clk);
    endtask : sq
    task automatic sr(input logic [7:0] a, input logic [7:0] exp);
        sq(1'b0, a, 8'h00);
        chk({23'h0, o_seq_rd_valid, o_seq_rd_data}, {23'h0, 1'b1, exp});
    endtask : sr
    task automatic alu(input logic ar, input logic [7:0] res, input logic cy);
        @(posedge i_core_clk);
        {i_alu_done, i_alu_arith, i_alu_result, i_alu_carry} <= {1'b1, ar, res, cy};
        @(posedge i_core_clk);
        i_alu_done <= 1'b0;
    endtask : alu
    task automatic stk(input logic push, input logic [8:0] a);
        @(posedge i_core_clk);
        {i_stack_push, i_stack_pop, i_stack_push_addr} <= {push, !push, a};
        @(posedge i_core_clk);
        {i_stack_push, i_stack_pop} <= 2'b00;
    endtask : stk
    // ----
    // Scenarios
    // ----
    task automatic t_ports;
        hr(8'h6E, 32'h01);
        alu(1'b1, 8'h00, 1'b1);
        hr(8'h6B, 32'h03);
        alu(1'b0, 8'h05, 1'b0);
        hw(8'h6B, 32'hFF);
        hr(8'h6B, 32'h01);
        sr(8'h6B, 8'h01);
        sq(1'b1, 8'h6A, 8'hFF);
        chk(32'(o_mem_wr), 32'h0);
        sr(8'h6A, 8'h00);
        hw(8'h6A, 32'hFF);
        hr(8'h6A, 32'h00);
        for (int v = 0; v < 8; v++) begin
            hw(8'h6E, 32'(8'h8F | (8'(v) << 4)));
            hr(8'h6E, 32'(8'h01 << v));
            sr(8'h6E, 8'h01 << v);
        end
        @(posedge i_core_clk);
        i_pstrb <= 4'hE;
        hw(8'h6E, 32'h10);
        i_pstrb <= 4'hF;
        hr(8'h6E, 32'h80);
    endtask : t_ports
    task automatic t_indirect;
        sq(1'b1, 8'h65, 8'hFE);
        sr(8'h6C, 8'hFE ^ 8'hA5);
        chk(32'(o_mem_rd_addr), 32'hFF);
        sr(8'h6C, 8'hFF ^ 8'hA5);
        chk(32'(o_src_ptr), 32'h00);
        sq(1'b1, 8'h66, 8'hFF);
        sq(1'b1, 8'h6D, 8'h5A);
        chk({o_mem_wr, o_mem_wr_addr, o_mem_wr_data}, {15'h0, 1'b1, 16'hFF5A});
        sq(1'b1, 8'h65, 8'hFF);
        sr(8'h6C, 8'h5A);
        chk(32'(o_dst_ptr), 32'h00);
        hr(8'h6C, 32'h00, 1'b1);
        hw(8'h6D, 32'h33, 1'b1);
        hr(8'h65, 32'h00, 1'b1);
        chk(32'(o_dst_ptr), 32'h00);
    endtask : t_indirect
    task automatic t_stack;
        logic [8:0] ent [4] = '{9'h044, 9'h1F3, 9'h002, 9'h101};
        stk(1'b1, 9'h101);
        stk(1'b1, 9'h002);
        stk(1'b1, 9'h1F3);
        stk(1'b1, 9'h0AA);
        stk(1'b0, 9'h000);
        stk(1'b1, 9'h044);
        for (int k = 0; k < 8; k++) begin
            hr(8'h6F, k % 2 ? 32'(ent[k / 2][8]) : 32'(ent[k / 2][7:0]));
            @(negedge i_core_clk);
            chk(32'(o_stack_top), 32'(ent[((k + 1) / 2) % 4]));
        end
        sr(8'h6F, 8'h44);
        sr(8'h6F, 8'h00);
        chk(32'(o_stack_top), 32'(ent[1]));
    endtask : t_stack
    task automatic summarize;
        $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        t_ports();
        t_indirect();
        t_stack();
        summarize();
    end
    // A hang anywhere ends the run through the same verdict
    initial begin
        repeat (20000) @(posedge i_core_clk);
        bad_count++;
        summarize();
    end
endmodule : ssp_special_ports_tb_top
`default_nettype wire
